/* File: inc/refs_pkg.sv */
// shared constants and carrier types for the remote error and setup flags block
package refs_pkg;
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_ESR = 8'h08;
	localparam logic [7:0] OFF_ERRQ = 8'h0c;
	localparam logic [7:0] OFF_VERSION = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_MONMODE = 8'h18;
	// event status register bit positions
	localparam int ESR_QUERY = 2;
	localparam int ESR_DEVICE = 3;
	localparam int ESR_EXEC = 4;
	localparam int ESR_CMD = 5;
	// command register bits, write one to trigger
	localparam int CMD_FACTORY = 0;
	localparam int CMD_STD_PRESET = 1;
	localparam int CMD_LEGACY_PRESET = 2;
	localparam int CMD_DEV_CLEAR = 3;
	localparam int CMD_RESET = 4;
	localparam int CMD_SAVE_FLAGS = 5;
	localparam int CMD_OUT_ON = 6;
	localparam int CMD_OUT_OFF = 7;
	localparam int CMD_CURR_MODE = 8;
	// error codes, two's complement
	localparam logic [15:0] CODE_CMD = 16'hff9c;
	localparam logic [15:0] CODE_NUMERIC = 16'hff88;
	localparam logic [15:0] CODE_PROTECTED = 16'hff35;
	localparam logic [15:0] CODE_CONFLICT = 16'hff23;
	localparam logic [15:0] CODE_RANGE = 16'hff22;
	localparam logic [15:0] CODE_TOO_MUCH = 16'hff21;
	localparam logic [15:0] CODE_LEN = 16'hff1e;
	localparam logic [15:0] CODE_HW = 16'hff10;
	localparam logic [15:0] CODE_VOLT = 16'hfed3;
	localparam logic [15:0] CODE_CURR = 16'hfed2;
	localparam logic [15:0] CODE_MEMORY = 16'hfec9;
	localparam logic [15:0] CODE_OVERFLOW = 16'hfea2;
	localparam logic [15:0] CODE_QUERY = 16'hfe70;
	localparam logic [15:0] CODE_UNTERM = 16'hfe5c;
	localparam int N_EVT = 13;
	localparam logic [15:0] VERSION_YEAR = 16'h07cd;
	localparam logic [8:0] OUTBUF_LIMIT = 9'h0fd;
	localparam logic [7:0] NEWLINE = 8'h0a;
	localparam logic [7:0] DWELL_SINGLE = 8'h01;
	localparam logic [1:0] MON_LOW = 2'h1;
	localparam logic [1:0] MON_HIGH = 2'h3;

	typedef struct packed {
		logic dc;
		logic lf;
		logic ro;
	} refs_flags_t;

	localparam refs_flags_t FLAGS_FACTORY = 3'h2;
	localparam refs_flags_t FLAGS_STD = 3'h0;
	localparam refs_flags_t FLAGS_LEGACY = 3'h7;

	typedef struct packed {
		logic cmd_extra;
		logic non_numeric;
		logic guarded_cmd;
		logic cal_cmd;
		logic list_dir_down;
		logic value_check;
		logic list_load;
		logic list_check;
		logic hw_no_reply;
		logic volt_window;
		logic curr_window;
		logic mem_fail;
		logic resp_done;
		logic query_unread;
		logic ovuv;
	} refs_faults_t;
endpackage

/* File: design/refs_err_mem.sv */
// error queue storage: one write port, registered read with write-through
`timescale 1ns/100ps
module refs_err_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 15,
	parameter int AW = 4
) (
	input wire logic ref_clk_i,
	input wire logic ce_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge ref_clk_i) begin
		if (ce_i && wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	// write-through so an entry pushed into an empty queue is readable at once
	always_ff @(posedge ref_clk_i) begin
		if (ce_i) begin
			if (wr_en_i && wr_addr_i == rd_addr_i) begin
				rd_data_o <= wr_data_i;
			end else begin
				rd_data_o <= mem[rd_addr_i];
			end
		end
	end
endmodule

/* File: design/refs_core.sv */
// error reporting, event status bits and persistent setup flags
`timescale 1ns/100ps
module refs_core #(
	parameter int Q_DEPTH = 15,
	parameter int LIST_CAP = 100,
	parameter logic [15:0] VERSION_REV = 16'h0000
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire refs_pkg::refs_faults_t faults_i,
	input wire logic password_unlock_state_i,
	input wire logic cal_enabled_i,
	input wire logic [15:0] setpoint_i,
	input wire logic [15:0] rating_i,
	input wire logic [7:0] list_fill_i,
	input wire logic [7:0] list_add_i,
	input wire logic [7:0] dwell_count_i,
	input wire logic [7:0] list_count_i,
	input wire logic [8:0] resp_len_i,
	input wire logic dev_clear_i,
	input wire logic host_read_i,
	input wire logic outbuf_empty_i,
	input wire refs_pkg::refs_flags_t nv_flags_i,
	output refs_pkg::refs_flags_t flags_o,
	output logic nv_save_o,
	output logic out_enable_o,
	output logic volt_mode_o,
	output logic zero_setpoints_o,
	output logic reply_valid_o,
	output logic [7:0] reply_char_o,
	output logic [5:0] esr_o
);
	localparam int AW = $clog2(Q_DEPTH);
	localparam int CW = $clog2(Q_DEPTH + 1);
	localparam logic [CW-1:0] Q_FULL = CW'(Q_DEPTH);
	localparam logic [CW-1:0] Q_LAST = CW'(Q_DEPTH - 1);
	localparam logic [AW-1:0] PTR_TOP = AW'(Q_DEPTH - 1);

	function automatic logic [15:0] evt_code(input logic [3:0] idx);
		unique case (idx)
			4'h0: evt_code = refs_pkg::CODE_CMD;
			4'h1: evt_code = refs_pkg::CODE_NUMERIC;
			4'h2: evt_code = refs_pkg::CODE_PROTECTED;
			4'h3: evt_code = refs_pkg::CODE_CONFLICT;
			4'h4: evt_code = refs_pkg::CODE_RANGE;
			4'h5: evt_code = refs_pkg::CODE_TOO_MUCH;
			4'h6: evt_code = refs_pkg::CODE_LEN;
			4'h7: evt_code = refs_pkg::CODE_HW;
			4'h8: evt_code = refs_pkg::CODE_VOLT;
			4'h9: evt_code = refs_pkg::CODE_CURR;
			4'ha: evt_code = refs_pkg::CODE_MEMORY;
			4'hb: evt_code = refs_pkg::CODE_QUERY;
			4'hc: evt_code = refs_pkg::CODE_UNTERM;
			default: evt_code = 16'h0000;
		endcase
	endfunction

	// event class to status bit: command, execution, device, query
	function automatic int evt_esr(input logic [3:0] idx);
		if (idx <= 4'h1) begin
			evt_esr = refs_pkg::ESR_CMD;
		end else if (idx <= 4'h7) begin
			evt_esr = refs_pkg::ESR_EXEC;
		end else if (idx <= 4'ha) begin
			evt_esr = refs_pkg::ESR_DEVICE;
		end else begin
			evt_esr = refs_pkg::ESR_QUERY;
		end
	endfunction

	function automatic logic [3:0] lowest(input logic [refs_pkg::N_EVT-1:0] v);
		lowest = 4'h0;
		for (int i = refs_pkg::N_EVT - 1; i >= 0; i--) begin
			if (v[i]) begin
				lowest = 4'(i);
			end
		end
	endfunction

	logic ack;
	logic load_nv;
	logic [1:0] mon_mode;
	logic [refs_pkg::N_EVT-1:0] evt;
	logic [refs_pkg::N_EVT-1:0] pend;
	logic [3:0] sel;
	logic have_evt;
	logic push;
	logic [15:0] push_code;
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [CW-1:0] count;
	logic [15:0] head_code;
	logic mon_active;

	// bus side: every access is answered on its second enabled cycle
	wire req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~(ack & ce_i);
	wire take = req & ack & ce_i;
	wire wr_take = take & avs_write_i & avs_byteenable_i[0];
	wire [31:0] wd = avs_writedata_i;
	wire cmd_wr = wr_take & avs_address_i == refs_pkg::OFF_CMD;
	wire pop = take & avs_read_i & avs_address_i == refs_pkg::OFF_ERRQ & count != '0;
	wire clear_in = dev_clear_i | (cmd_wr & wd[refs_pkg::CMD_DEV_CLEAR]);
	wire clear_status = clear_in & ~flags_o.dc;
	wire as_reset = (cmd_wr & wd[refs_pkg::CMD_RESET]) | (clear_in & flags_o.dc);

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ack <= 1'b0;
		end else if (ce_i) begin
			ack <= req & ~ack;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (ce_i && req && !ack) begin
			unique case (avs_address_i)
				refs_pkg::OFF_CONFIG: avs_readdata_o <= {29'h0, flags_o};
				refs_pkg::OFF_ESR: avs_readdata_o <= {26'h0, esr_o};
				refs_pkg::OFF_ERRQ: begin
					// an empty queue reads as code zero, no error
					avs_readdata_o <= (count != '0) ? {{16{head_code[15]}}, head_code}
						: 32'h0000_0000;
				end
				refs_pkg::OFF_VERSION: begin
					avs_readdata_o <= {refs_pkg::VERSION_YEAR, VERSION_REV};
				end
				refs_pkg::OFF_STATUS: begin
					avs_readdata_o <= {16'h0, 8'(count), 6'h0, volt_mode_o, out_enable_o};
				end
				refs_pkg::OFF_MONMODE: avs_readdata_o <= {30'h0, mon_mode};
				default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			mon_mode <= 2'h0;
		end else if (ce_i && wr_take && avs_address_i == refs_pkg::OFF_MONMODE) begin
			mon_mode <= wd[1:0];
		end
	end

	// setup flags: power-up value comes from the non-volatile copy
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			load_nv <= 1'b1;
			flags_o <= refs_pkg::FLAGS_STD;
		end else if (ce_i) begin
			load_nv <= 1'b0;
			if (load_nv) begin
				flags_o <= nv_flags_i;
			end else if (cmd_wr && wd[refs_pkg::CMD_FACTORY]) begin
				flags_o <= refs_pkg::FLAGS_FACTORY;
			end else if (cmd_wr && wd[refs_pkg::CMD_STD_PRESET]) begin
				flags_o <= refs_pkg::FLAGS_STD;
			end else if (cmd_wr && wd[refs_pkg::CMD_LEGACY_PRESET]) begin
				flags_o <= refs_pkg::FLAGS_LEGACY;
			end else if (wr_take && avs_address_i == refs_pkg::OFF_CONFIG) begin
				flags_o <= wd[2:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			nv_save_o <= 1'b0;
		end else if (ce_i) begin
			nv_save_o <= cmd_wr & wd[refs_pkg::CMD_SAVE_FLAGS];
		end
	end

	// output state; a window fault wins over an on request
	assign mon_active = mon_mode >= refs_pkg::MON_LOW && mon_mode <= refs_pkg::MON_HIGH;
	wire window_trip = mon_active & (faults_i.volt_window | faults_i.curr_window);

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			out_enable_o <= 1'b0;
			volt_mode_o <= 1'b1;
			zero_setpoints_o <= 1'b1;
		end else if (ce_i) begin
			zero_setpoints_o <= as_reset;
			if (window_trip) begin
				out_enable_o <= 1'b0;
			end else if (as_reset) begin
				out_enable_o <= flags_o.ro;
				volt_mode_o <= 1'b1;
			end else if (cmd_wr && wd[refs_pkg::CMD_OUT_OFF]) begin
				out_enable_o <= 1'b0;
			end else if (cmd_wr && wd[refs_pkg::CMD_OUT_ON]) begin
				out_enable_o <= 1'b1;
			end
			if (!as_reset && cmd_wr && wd[refs_pkg::CMD_CURR_MODE]) begin
				volt_mode_o <= 1'b0;
			end
		end
	end

	// empty-buffer read answers with a newline or with nothing
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			reply_valid_o <= 1'b0;
			reply_char_o <= 8'h00;
		end else if (ce_i) begin
			reply_valid_o <= host_read_i & outbuf_empty_i & flags_o.lf;
			reply_char_o <= refs_pkg::NEWLINE;
		end
	end

	// fault detection
	wire [8:0] list_total = {1'b0, list_fill_i} + {1'b0, list_add_i};
	assign evt[0] = faults_i.cmd_extra;
	assign evt[1] = faults_i.non_numeric;
	assign evt[2] = faults_i.guarded_cmd & ~password_unlock_state_i;
	assign evt[3] = (faults_i.cal_cmd & ~cal_enabled_i) | faults_i.list_dir_down;
	assign evt[4] = faults_i.value_check & (setpoint_i > rating_i);
	assign evt[5] = faults_i.list_load & (list_total > 9'(LIST_CAP));
	assign evt[6] = faults_i.list_check & dwell_count_i != refs_pkg::DWELL_SINGLE
		& dwell_count_i != list_count_i;
	assign evt[7] = faults_i.hw_no_reply;
	assign evt[8] = mon_active & faults_i.volt_window;
	assign evt[9] = mon_active & faults_i.curr_window;
	assign evt[10] = faults_i.mem_fail;
	assign evt[11] = faults_i.resp_done & (resp_len_i > refs_pkg::OUTBUF_LIMIT);
	assign evt[12] = faults_i.query_unread;

	// events wait here until selected, one per cycle, lowest first; a full queue drops the selected one
	assign have_evt = pend != '0;
	assign sel = lowest(pend);

	genvar gi;
	generate
		for (gi = 0; gi < refs_pkg::N_EVT; gi++) begin : g_pend
			always_ff @(posedge ref_clk_i) begin
				if (reset_i) begin
					pend[gi] <= 1'b0;
				end else if (ce_i) begin
					pend[gi] <= evt[gi] | (pend[gi] & ~(have_evt && sel == 4'(gi)));
				end
			end
		end
	endgenerate

	// the last slot holds the overflow mark; later events are dropped
	assign push = have_evt & count < Q_FULL;
	assign push_code = (count == Q_LAST) ? refs_pkg::CODE_OVERFLOW : evt_code(sel);
	assign next_rd_ptr = pop ? ((rd_ptr == PTR_TOP) ? '0 : rd_ptr + 1'b1) : rd_ptr;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (ce_i) begin
			rd_ptr <= next_rd_ptr;
			if (push) begin
				wr_ptr <= (wr_ptr == PTR_TOP) ? '0 : wr_ptr + 1'b1;
			end
			count <= count + CW'(push) - CW'(pop);
		end
	end

	refs_err_mem #(.WIDTH(16), .DEPTH(Q_DEPTH), .AW(AW)) u_mem (
		.ref_clk_i(ref_clk_i),
		.ce_i(ce_i),
		.wr_en_i(push),
		.wr_addr_i(wr_ptr),
		.wr_data_i(push_code),
		.rd_addr_i(next_rd_ptr),
		.rd_data_o(head_code)
	);

	// sticky status bits; a new event wins over a clear in the same cycle
	logic [5:0] esr_set;
	logic [5:0] esr_clr;
	always_comb begin
		esr_set = 6'h00;
		if (have_evt) begin
			esr_set[evt_esr(sel)] = 1'b1;
		end
		if (have_evt && count >= Q_LAST) begin
			esr_set[refs_pkg::ESR_DEVICE] = 1'b1;
		end
		if (faults_i.ovuv) begin
			esr_set[refs_pkg::ESR_DEVICE] = 1'b1;
		end
		esr_clr = 6'h00;
		if (wr_take && avs_address_i == refs_pkg::OFF_ESR) begin
			esr_clr = wd[5:0];
		end
		if (clear_status || as_reset) begin
			esr_clr = 6'h3f;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			esr_o <= 6'h00;
		end else if (ce_i) begin
			esr_o <= ((esr_o & ~esr_clr) | esr_set) & 6'h3c;
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	sequence lf_empty_read;
		ce_i && host_read_i && outbuf_empty_i;
	endsequence

	sequence clear_as_reset;
		ce_i && clear_in && flags_o.dc && !window_trip;
	endsequence

	cmd_error_bit_a: assert property (ce_i && have_evt && sel <= 4'h1
		|=> esr_o[refs_pkg::ESR_CMD]) else $error("command error bit not set");
	protect_err_a: assert property (ce_i && faults_i.guarded_cmd
		&& !password_unlock_state_i |=> pend[2]) else $error("protected error not queued");
	range_err_a: assert property (ce_i && faults_i.value_check
		&& setpoint_i > rating_i |=> pend[4]) else $error("range error not queued");
	window_off_a: assert property (ce_i && window_trip |=> !out_enable_o
		&& pend[8] == $past(faults_i.volt_window)) else $error("window fault mishandled");
	queue_keep_a: assert property (ce_i && count == Q_FULL && !pop
		|=> count == Q_FULL && $stable(wr_ptr)) else $error("full queue changed");
	overflow_mark_a: assert property (ce_i && have_evt && count == Q_LAST && !pop
		|=> esr_o[refs_pkg::ESR_DEVICE] && count == Q_FULL) else $error("overflow not marked");
	newline_reply_a: assert property (lf_empty_read ##0 flags_o.lf
		|=> reply_valid_o && reply_char_o == refs_pkg::NEWLINE) else $error("newline missing");
	no_newline_a: assert property (lf_empty_read ##0 !flags_o.lf
		|=> !reply_valid_o) else $error("newline sent while disabled");
	legacy_preset_a: assert property (ce_i && !load_nv && cmd_wr
		&& wd[refs_pkg::CMD_LEGACY_PRESET] && !wd[refs_pkg::CMD_FACTORY]
		&& !wd[refs_pkg::CMD_STD_PRESET] |=> flags_o == refs_pkg::FLAGS_LEGACY)
		else $error("legacy preset not applied");
	factory_flags_a: assert property (ce_i && !load_nv && cmd_wr
		&& wd[refs_pkg::CMD_FACTORY] |=> flags_o == refs_pkg::FLAGS_FACTORY)
		else $error("factory flags wrong");
	clear_reset_a: assert property (clear_as_reset |=> out_enable_o == $past(flags_o.ro)
		&& volt_mode_o && zero_setpoints_o ##1 !zero_setpoints_o || as_reset)
		else $error("clear did not act as reset");
	clear_only_a: assert property (ce_i && clear_status && !as_reset && !window_trip
		&& !cmd_wr |=> $stable(out_enable_o) && esr_o == $past(esr_set))
		else $error("status clear touched output");
	bus_answer_a: assert property (ce_i && req && !ack |=> !avs_waitrequest_o || !ce_i)
		else $error("bus answer late");
endmodule

/* File: bench/refs_host_model.sv */
// remote controller model: one-clock command events and a log of replies
`timescale 1ns/100ps
module refs_host_model (
	input wire logic ref_clk_i,
	input wire logic reply_valid_i,
	input wire logic [7:0] reply_char_i,
	output refs_pkg::refs_faults_t faults_o,
	output logic dev_clear_o,
	output logic host_read_o,
	output logic outbuf_empty_o
);
	int replies = 0;
	logic [7:0] last_char = 8'h00;
	initial begin
		faults_o = '0;
		dev_clear_o = 1'b0;
		host_read_o = 1'b0;
		outbuf_empty_o = 1'b0;
	end
	// each request lasts one clock, so each fault set in a call is seen in a single cycle
	task automatic pulse(input logic [14:0] f, input logic clr, input logic rd, input logic emp);
		@(posedge ref_clk_i);
		faults_o <= f;
		dev_clear_o <= clr;
		host_read_o <= rd;
		outbuf_empty_o <= emp;
		@(posedge ref_clk_i);
		faults_o <= '0;
		dev_clear_o <= 1'b0;
		host_read_o <= 1'b0;
		// idle level flips so a stale value is never mistaken for a qualifier
		outbuf_empty_o <= ~emp;
	endtask
	always @(posedge ref_clk_i) begin
		if (reply_valid_i) begin
			replies <= replies + 1;
			last_char <= reply_char_i;
		end
	end
endmodule

/* File: bench/remote_error_and_setup_flags_bench.sv */
// self-checking bench for the remote error and setup flags core
`timescale 1ns/100ps
module remote_error_and_setup_flags_bench;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hf;
	logic ce = 1'b1;
	logic unlock = 1'b0;
	logic cal_en = 1'b0;
	logic [15:0] setpoint = 16'h0100;
	logic [15:0] rating = 16'h00ff;
	logic [7:0] fill = 8'h3c;
	logic [7:0] add = 8'h29;
	logic [7:0] dwell = 8'h02;
	logic [7:0] lcount = 8'h03;
	logic [8:0] rlen = 9'h0fe;
	refs_pkg::refs_flags_t nv = 3'h5;
	refs_pkg::refs_flags_t flags;
	refs_pkg::refs_faults_t faults;
	logic [31:0] rdata;
	logic [31:0] q;
	logic [7:0] rchar;
	logic [5:0] esr;
	logic waitreq, dclr, hrd, hempty, nv_save, out_en, vmode, zero_sp, rvalid;
	logic zero_seen = 1'b0;
	int bad_count = 0;
	int samples_checked = 0;
	int r0;
	int fbit[14] = '{14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1};
	int fcode[14] = '{-100, -120, -203, -221, -221, -222, -223, -226, -240, -301, -302, -311,
		-400, -420};
	int fesr[14] = '{5, 5, 4, 4, 4, 4, 4, 4, 4, 3, 3, 3, 2, 2};
	always #5 ref_clk_i = ~ref_clk_i;
	// stands in for the non-volatile store that outlives a reset
	always @(posedge ref_clk_i) begin
		if (nv_save) begin
			nv <= flags;
		end
		if (zero_sp) begin
			zero_seen <= 1'b1;
		end
	end
	refs_core #(.LIST_CAP(100)) i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
		.faults_i(faults), .password_unlock_state_i(unlock), .cal_enabled_i(cal_en),
		.setpoint_i(setpoint), .rating_i(rating), .list_fill_i(fill), .list_add_i(add),
		.dwell_count_i(dwell), .list_count_i(lcount), .resp_len_i(rlen), .dev_clear_i(dclr),
		.host_read_i(hrd), .outbuf_empty_i(hempty), .nv_flags_i(nv), .flags_o(flags),
		.nv_save_o(nv_save), .out_enable_o(out_en), .volt_mode_o(vmode),
		.zero_setpoints_o(zero_sp), .reply_valid_o(rvalid), .reply_char_o(rchar), .esr_o(esr));
	refs_host_model i_host (.ref_clk_i(ref_clk_i), .reply_valid_i(rvalid), .reply_char_i(rchar),
		.faults_o(faults), .dev_clear_o(dclr), .host_read_o(hrd), .outbuf_empty_o(hempty));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= ~w;
		// waitrequest is sampled at the rising edge, where the access is taken
		while (!done && n < 50) begin
			@(posedge ref_clk_i);
			done = (waitreq === 1'b0);
			n++;
		end
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (!done) begin
			bad_count++;
			$display("[FAIL] bus handshake expected %h seen %h", 1'b0, waitreq);
			print_verdict();
		end
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(what, q, exp);
	endtask
	task automatic fire(input logic [14:0] f, input logic clr, input logic hr, input logic emp);
		i_host.pulse(f, clr, hr, emp);
		repeat (3) @(negedge ref_clk_i);
	endtask
	task automatic clear_esr;
		bus(1'b1, refs_pkg::OFF_ESR, 32'h3c);
		@(negedge ref_clk_i);
		check("status cleared", esr, 32'h0);
	endtask
	task automatic do_reset;
		@(posedge ref_clk_i);
		reset_i <= 1'b1;
		repeat (5) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		repeat (2) @(negedge ref_clk_i);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		bad_count++;
		print_verdict();
	end
	initial begin
		do_reset();
		check("power-up flags", flags, 32'h5);
		check("power-up output", {vmode, out_en}, 32'h2);
		rd_chk("version", refs_pkg::OFF_VERSION, {16'h07cd, 16'h0000});
		rd_chk("unmapped", 8'h1c, 32'h0);
		bus(1'b1, refs_pkg::OFF_MONMODE, 32'h3);
		for (int i = 0; i < 14; i++) begin
			bus(1'b1, refs_pkg::OFF_CMD, 32'h40);
			fire(15'h1 << fbit[i], 1'b0, 1'b0, 1'b0);
			check("event status", esr, 32'h1 << fesr[i]);
			check("window off", out_en, (fbit[i] == 5 || fbit[i] == 4) ? 32'h0 : 32'h1);
			rd_chk("queue head", refs_pkg::OFF_ERRQ, fcode[i]);
			rd_chk("queue empty", refs_pkg::OFF_ERRQ, 32'h0);
			clear_esr();
		end
		// every numeric qualifier sits exactly on its limit and unlock, calibration enable and monitor mode 0 mask the rest, so nothing may be reported
		bus(1'b1, refs_pkg::OFF_MONMODE, 32'h0);
		unlock <= 1'b1;
		cal_en <= 1'b1;
		rating <= 16'h0100;
		add <= 8'h28;
		dwell <= 8'h01;
		rlen <= 9'h0fd;
		bus(1'b1, refs_pkg::OFF_CMD, 32'h40);
		fire(15'h1ba4, 1'b0, 1'b0, 1'b0);
		check("no event", {out_en, esr}, 32'h40);
		rd_chk("queue still empty", refs_pkg::OFF_ERRQ, 32'h0);
		for (int i = 0; i < 17; i++) begin
			i_host.pulse(i[0] ? 15'h2000 : 15'h4000, 1'b0, 1'b0, 1'b0);
		end
		repeat (3) @(negedge ref_clk_i);
		check("overflow status", esr, 32'h28);
		for (int i = 0; i < 15; i++) begin
			rd_chk("queue order", refs_pkg::OFF_ERRQ, i == 14 ? -350 : (i[0] ? -120 : -100));
		end
		rd_chk("queue drained", refs_pkg::OFF_ERRQ, 32'h0);
		clear_esr();
		// a pulse while the clock enable is low is never taken
		ce <= 1'b0;
		fire(15'h4000, 1'b0, 1'b0, 1'b0);
		check("frozen status", esr, 32'h0);
		ce <= 1'b1;
		rd_chk("frozen queue", refs_pkg::OFF_ERRQ, 32'h0);
		fire(15'h1, 1'b0, 1'b0, 1'b0);
		check("ovuv device bit", esr, 32'h08);
		rd_chk("ovuv not queued", refs_pkg::OFF_ERRQ, 32'h0);
		clear_esr();
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, refs_pkg::OFF_CMD, 32'h1 << i);
			rd_chk("preset flags", refs_pkg::OFF_CONFIG, i == 0 ? 2 : (i == 1 ? 0 : 7));
		end
		be <= 4'h0;
		bus(1'b1, refs_pkg::OFF_CONFIG, 32'h0);
		be <= 4'hf;
		rd_chk("lane off write", refs_pkg::OFF_CONFIG, 32'h7);
		bus(1'b1, refs_pkg::OFF_CMD, 32'h42);
		fire(15'h4000, 1'b0, 1'b0, 1'b0);
		fire(15'h0, 1'b1, 1'b0, 1'b0);
		check("status-only clear", {out_en, esr}, 32'h40);
		rd_chk("queue kept", refs_pkg::OFF_ERRQ, -100);
		bus(1'b1, refs_pkg::OFF_CMD, 32'h184);
		zero_seen <= 1'b0;
		fire(15'h0, 1'b1, 1'b0, 1'b0);
		check("clear as reset", {zero_seen, vmode, out_en}, 32'h7);
		bus(1'b1, refs_pkg::OFF_CONFIG, 32'h4);
		bus(1'b1, refs_pkg::OFF_CMD, 32'h140);
		fire(15'h0, 1'b1, 1'b0, 1'b0);
		check("clear output off", {vmode, out_en}, 32'h2);
		bus(1'b1, refs_pkg::OFF_CONFIG, 32'h1);
		bus(1'b1, refs_pkg::OFF_CMD, 32'h10);
		@(negedge ref_clk_i);
		check("reset output on", {vmode, out_en}, 32'h3);
		bus(1'b1, refs_pkg::OFF_CONFIG, 32'h0);
		zero_seen <= 1'b0;
		bus(1'b1, refs_pkg::OFF_CMD, 32'h140);
		bus(1'b1, refs_pkg::OFF_CMD, 32'h10);
		repeat (2) @(negedge ref_clk_i);
		check("reset output off", {zero_seen, vmode, out_en}, 32'h6);
		r0 = i_host.replies;
		fire(15'h0, 1'b0, 1'b1, 1'b1);
		check("newline disabled", i_host.replies, r0);
		bus(1'b1, refs_pkg::OFF_CONFIG, 32'h2);
		fire(15'h0, 1'b0, 1'b1, 1'b1);
		check("newline reply", i_host.replies, r0 + 1);
		check("newline char", i_host.last_char, 32'h0a);
		fire(15'h0, 1'b0, 1'b1, 1'b0);
		check("buffer not empty", i_host.replies, r0 + 1);
		bus(1'b1, refs_pkg::OFF_CONFIG, 32'h3);
		bus(1'b1, refs_pkg::OFF_CMD, 32'h60);
		do_reset();
		check("restored flags", flags, 32'h3);
		rd_chk("power-up status", refs_pkg::OFF_STATUS, 32'h2);
		print_verdict();
	end
endmodule
